// File: lcd_pixel_pkg.sv
// package: constants and carrier types for the lcd pixel palette and dither block
package lcd_pixel_pkg;

    localparam int unsigned LUT_DEPTH = 256;
    localparam int unsigned LUT_AW    = 8;
    localparam int unsigned PAT_SETS  = 8;
    localparam int unsigned PAT_W     = 28;
    localparam int unsigned CTRL_W    = 7;

    localparam logic [11:0] LUT_BASE      = 12'h000;
    localparam logic [11:0] CTRL_OFFSET   = 12'h400;
    localparam logic [11:0] STATUS_OFFSET = 12'h404;
    localparam logic [11:0] PAT_BASE      = 12'h420;
    localparam logic [3:0]  FULL_WORD     = 4'hF;

    localparam logic [6:0] WORD_BITS  = 7'h20;
    localparam logic [4:0] PIX_MAX_W  = 5'h18;
    localparam logic [3:0] PACK_BITS  = 4'hB;
    localparam logic [3:0] UNIT_NARROW = 4'h4;
    localparam logic [3:0] UNIT_WIDE   = 4'h8;
    localparam logic [3:0] GRAY_FULL   = 4'hF;
    localparam logic [3:0] GRAY_HALF   = 4'h8;

    // pattern set indices
    localparam logic [2:0] pattern_six_sevenths   = 3'h0;
    localparam logic [2:0] pattern_four_fifths    = 3'h1;
    localparam logic [2:0] pattern_three_quarters = 3'h2;
    localparam logic [2:0] pattern_five_sevenths  = 3'h3;
    localparam logic [2:0] pattern_two_thirds     = 3'h4;
    localparam logic [2:0] pattern_three_fifths   = 3'h5;
    localparam logic [2:0] pattern_four_sevenths  = 3'h6;
    localparam logic [2:0] pattern_one_half       = 3'h7;

    // number of 4-bit patterns in each set, in set index order
    localparam logic [2:0] PAT_LEN [PAT_SETS] = '{3'h7, 3'h5, 3'h4, 3'h7, 3'h3, 3'h5, 3'h7, 3'h2};

    typedef enum logic [1:0] {DISP_TFT, DISP_STN_MONO, DISP_STN_COLOR} display_type_t;
    typedef enum logic [2:0] {PW_1, PW_2, PW_4, PW_8, PW_16, PW_24} pixel_width_t;
    typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_DONE} bus_state_t;

    typedef struct packed {
        logic          bus_eight;
        logic          word_byte_order_select;
        pixel_width_t  pixel_width_select;
        display_type_t display_type_select;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = '{bus_eight: 1'b0, word_byte_order_select: 1'b1,
                                     pixel_width_select: PW_1, display_type_select: DISP_TFT};

    typedef struct packed {
        logic       intensity;
        logic [4:0] blue;
        logic [4:0] green;
        logic [4:0] red;
    } lut_entry_t;

    typedef struct packed {
        logic [11:0] address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } avs_req_t;

    typedef struct packed {
        bus_state_t                        bus;
        logic [31:0]                       rdata;
        ctrl_t                             ctrl;
        logic [PAT_SETS-1:0][PAT_W-1:0]    pat;
        logic [PAT_SETS-1:0][2:0]          pidx;
        logic [63:0]                       acc;
        logic [6:0]                        cnt;
        logic [1:0]                        pos;
        logic                              a_valid;
        logic [23:0]                       a_pix;
        logic [1:0]                        a_pos;
        logic [10:0]                       pk;
        logic [3:0]                        pk_cnt;
        logic                              o_valid;
        logic [23:0]                       o_data;
    } state_t;

endpackage

// File: lcd_lut_ram.sv
// lookup table storage: one write port, two registered read ports
`timescale 1ns/100ps
module lcd_lut_ram
    import lcd_pixel_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              ce_i,
    input  wire logic              we_i,
    input  wire logic [LUT_AW-1:0] waddr_i,
    input  wire lut_entry_t        wdata_i,
    input  wire logic              a_re_i,
    input  wire logic [LUT_AW-1:0] a_addr_i,
    output lut_entry_t             a_rdata_o,
    input  wire logic              b_re_i,
    input  wire logic [LUT_AW-1:0] b_addr_i,
    output lut_entry_t             b_rdata_o
);
    lut_entry_t mem [LUT_DEPTH];

    // read data hold while the read enable is low, so a stalled pixel keeps its entry
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem[waddr_i] <= wdata_i;
            end
            if (a_re_i) begin
                a_rdata_o <= mem[a_addr_i];
            end
            if (b_re_i) begin
                b_rdata_o <= mem[b_addr_i];
            end
        end
    end
endmodule

// File: lcd_pixel_palette_dither.sv
// lcd datapath: pixel unpacking, palette lookup, tft mapping and stn frame-rate dithering
`timescale 1ns/100ps
// Behaviour
// - big-endian: pixel 0 at word MSB; wider pixels MSB-first; 24 bpp spans words
// - palette used for listed low-depth modes; 16/24 bpp and mono 4/8 bpp pass through
// - lookup table of 256 sixteen-bit entries indexed by the pixel value
// - entry layout: red 4:0, green 9:5, blue 14:10, intensity bit 15
// - host reads/writes table, one entry per word, full-word writes only
// - stn mono uses the top four red bits as gray level; mono 4/8 bpp use the low four pixel bits
// - stn colour uses the top four bits of red, green and blue
// - palettised tft outputs five bits per colour, intensity on bits 18, 10, 2
// - palettised tft holds bits 17:16, 9:8 and 1:0 at zero
// - stn only: shades made by frame-rate control from the 4-bit gray level
// - level 15 on, 0 off, others use the host-written pattern sets
// - levels 1/14, 2/13, 3/12, 4/10, 5/9, 6/8 share a set; lower level uses the inverted pattern
// - pixel at 4n+m lit when bit 3-m of the current pattern is one
// - next pattern of each set every frame, wrapping after the last
// - colour: r, g, b sub-pixels form one run; bit 3 minus run index mod 4
// - colour sub-pixels fill bus bits 3..0 or 7..0, first sub-pixel highest
// - dual scan: each panel bus dithered and ordered like single scan; the code has no dual scan mode and drives one panel bus only
// - pixel width 1..24 bits and word byte order selected by settings
// - display type selects tft, stn mono or stn colour behaviour
module lcd_pixel_palette_dither
    import lcd_pixel_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire avs_req_t    avs_req_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic [31:0] word_i,
    input  wire logic        word_valid_i,
    output logic             word_ready_o,
    input  wire logic        frame_start_i,
    input  wire logic        line_start_i,
    output logic             pixel_valid_o,
    input  wire logic        pixel_ready_i,
    output logic [23:0]      panel_data_bus_o
);

    function automatic logic [4:0] pw_bits(input pixel_width_t pw);
        case (pw)
            PW_1:    return 5'h01;
            PW_2:    return 5'h02;
            PW_4:    return 5'h04;
            PW_8:    return 5'h08;
            PW_16:   return 5'h10;
            PW_24:   return PIX_MAX_W;
            default: return 5'h01;
        endcase
    endfunction

    // little-endian: pixel 0 at the low end; bytes swap for 24 bpp
    function automatic logic [31:0] reorder(input logic [31:0] w, input pixel_width_t pw,
                                            input logic big);
        logic [31:0] r;
        logic [4:0]  f;
        f = (pw == PW_24) ? 5'h07 : 5'(pw_bits(pw) - 5'h01);
        for (int i = 0; i < 32; i++) begin
            r[i] = w[5'(31 - i) ^ f];
        end
        return big ? w : r;
    endfunction

    function automatic logic is_palettised(input display_type_t dt, input pixel_width_t pw);
        case (dt)
            DISP_TFT:       return pw <= PW_8;
            DISP_STN_MONO:  return pw <= PW_2;
            DISP_STN_COLOR: return pw <= PW_8;
            default:        return 1'b0;
        endcase
    endfunction

    function automatic logic pattern_for(input logic [3:0] lvl, input logic [1:0] m,
                                         input logic [PAT_SETS-1:0][PAT_W-1:0] pat,
                                         input logic [PAT_SETS-1:0][2:0] idx);
        logic [2:0]       sel;
        logic [PAT_W-1:0] p;
        logic [3:0]       q;
        case (lvl)
            4'hE, 4'h1: sel = pattern_six_sevenths;
            4'hD, 4'h2: sel = pattern_four_fifths;
            4'hC, 4'h3: sel = pattern_three_quarters;
            4'hB:       sel = pattern_five_sevenths;
            4'hA, 4'h4: sel = pattern_two_thirds;
            4'h9, 4'h5: sel = pattern_three_fifths;
            4'h8, 4'h6: sel = pattern_four_sevenths;
            default:    sel = pattern_one_half;
        endcase
        p = pat[sel];
        q = p[int'(PAT_W) - 4 - 4 * int'(idx[sel]) +: 4];
        if (lvl == GRAY_FULL) begin
            return 1'b1;
        end else if (lvl == 4'h0) begin
            return 1'b0;
        end
        q = (lvl < GRAY_HALF) ? ~q : q;
        return q[~m];
    endfunction

    state_t     s;
    state_t     next_s;
    lut_entry_t lut_pix;
    lut_entry_t lut_host;
    logic       lut_we;
    logic       lut_a_re;
    logic       lut_b_re;
    logic [7:0] lut_a_addr;
    logic [4:0]    w;
    display_type_t dt;
    logic          stn;
    logic          colour;
    logic          pal;
    logic [3:0]    unit;
    logic [3:0]    nbits;
    logic          out_free;
    logic          a_move;
    logic          take;
    lut_entry_t    entry;
    logic [3:0]    lvl;
    logic          bit_r;
    logic          bit_g;
    logic          bit_b;
    logic [1:0]    p1;
    logic [1:0]    p2;

    lcd_lut_ram u_lut (
        .clk_i     (clk_i),
        .ce_i      (ce_i),
        .we_i      (lut_we),
        .waddr_i   (avs_req_i.address[9:2]),
        .wdata_i   (lut_entry_t'(avs_req_i.writedata[15:0])),
        .a_re_i    (lut_a_re),
        .a_addr_i  (lut_a_addr),
        .a_rdata_o (lut_pix),
        .b_re_i    (lut_b_re),
        .b_addr_i  (avs_req_i.address[9:2]),
        .b_rdata_o (lut_host)
    );

    always_comb begin
        logic          aligned;
        logic          is_lut;
        logic          is_pat;
        aligned  = 1'b0;
        is_lut   = 1'b0;
        is_pat   = 1'b0;
        next_s   = s;
        lut_we   = 1'b0;
        lut_b_re = 1'b0;

        // register bus slave
        aligned = (avs_req_i.address[1:0] == 2'b00);
        is_lut  = aligned && (avs_req_i.address < CTRL_OFFSET) && (avs_req_i.address >= LUT_BASE);
        is_pat  = aligned && (avs_req_i.address[11:5] == PAT_BASE[11:5]);
        avs_waitrequest_o = !(ce_i && ((s.bus == BUS_IDLE && avs_req_i.write)
                                       || s.bus == BUS_DONE));
        case (s.bus)
            BUS_IDLE: begin
                if (avs_req_i.write) begin
                    // partial writes are dropped; table writes store only the lower half of the data
                    if (avs_req_i.byteenable == FULL_WORD) begin
                        lut_we = ce_i && is_lut;
                        if (aligned && avs_req_i.address == CTRL_OFFSET) begin
                            next_s.ctrl = ctrl_t'(avs_req_i.writedata[CTRL_W-1:0]);
                        end
                        if (is_pat) begin
                            next_s.pat[avs_req_i.address[4:2]] = avs_req_i.writedata[PAT_W-1:0];
                        end
                    end
                end else if (avs_req_i.read) begin
                    next_s.bus = BUS_DONE;
                    next_s.rdata = 32'h0000_0000;
                    if (is_lut) begin
                        lut_b_re    = ce_i;
                        next_s.bus  = BUS_FETCH;
                    end else if (aligned && avs_req_i.address == CTRL_OFFSET) begin
                        next_s.rdata = {25'h0, s.ctrl};
                    end else if (aligned && avs_req_i.address == STATUS_OFFSET) begin
                        next_s.rdata = {6'h00, s.o_valid, s.a_valid, s.pidx};
                    end else if (is_pat) begin
                        next_s.rdata = {4'h0, s.pat[avs_req_i.address[4:2]]};
                    end
                end
            end
            BUS_FETCH: begin
                next_s.rdata = {16'h0000, lut_host};
                next_s.bus   = BUS_DONE;
            end
            BUS_DONE: begin
                next_s.bus = BUS_IDLE;
            end
            default: begin
                next_s.bus = BUS_IDLE;
            end
        endcase

        // mode decode
        w        = pw_bits(s.ctrl.pixel_width_select);
        dt       = s.ctrl.display_type_select;
        stn      = (dt != DISP_TFT);
        colour   = (dt == DISP_STN_COLOR);
        pal      = is_palettised(dt, s.ctrl.pixel_width_select);
        unit     = s.ctrl.bus_eight ? UNIT_WIDE : UNIT_NARROW;
        nbits    = colour ? 4'h3 : 4'h1;
        out_free = !s.o_valid || pixel_ready_i;

        // output slot and stn packer drain
        if (s.o_valid && pixel_ready_i) begin
            next_s.o_valid = 1'b0;
        end
        if (stn && out_free && s.pk_cnt >= unit) begin
            next_s.o_valid = 1'b1;
            next_s.o_data  = s.ctrl.bus_eight ? {16'h0000, s.pk[10:3]}
                                              : {20'h00000, s.pk[10:7]};
            next_s.pk      = s.pk << unit;
            next_s.pk_cnt  = s.pk_cnt - unit;
        end

        // stage a: palette entry ready this cycle
        entry = pal ? lut_pix : lut_entry_t'(s.a_pix[15:0]);
        p1    = 2'(s.a_pos + 2'h1);
        p2    = 2'(s.a_pos + 2'h2);
        lvl   = (dt == DISP_STN_MONO && !pal) ? s.a_pix[3:0] : entry.red[4:1];
        bit_r = pattern_for(lvl, s.a_pos, s.pat, s.pidx);
        bit_g = pattern_for(entry.green[4:1], p1, s.pat, s.pidx);
        bit_b = pattern_for(entry.blue[4:1], p2, s.pat, s.pidx);
        a_move = s.a_valid && (stn ? (next_s.pk_cnt + nbits <= PACK_BITS) : out_free);
        if (a_move) begin
            if (stn) begin
                next_s.pk = next_s.pk | (colour ? {bit_r, bit_g, bit_b, 8'h00}
                                                : {bit_r, 10'h000}) >> next_s.pk_cnt;
                next_s.pk_cnt = next_s.pk_cnt + nbits;
            end else begin
                next_s.o_valid = 1'b1;
                if (s.ctrl.pixel_width_select == PW_24) begin
                    next_s.o_data = s.a_pix;
                end else begin
                    next_s.o_data = {entry.blue, entry.intensity, 2'b00,
                                     entry.green, entry.intensity, 2'b00,
                                     entry.red, entry.intensity, 2'b00};
                end
            end
            next_s.a_valid = 1'b0;
        end

        // serializer: next pixel from the accumulator top
        take       = (!s.a_valid || a_move) && (s.cnt >= 7'(w));
        lut_a_re   = ce_i && take;
        lut_a_addr = s.acc[63:56] >> (5'h08 - ((w > 5'h08) ? 5'h08 : w));
        if (take) begin
            next_s.a_valid = 1'b1;
            next_s.a_pix   = s.acc[63:40] >> (PIX_MAX_W - w);
            next_s.a_pos   = s.pos;
            next_s.pos     = 2'(s.pos + (colour ? 2'h3 : 2'h1));
            next_s.acc     = s.acc << w;
            next_s.cnt     = s.cnt - 7'(w);
        end
        // a word is taken only when a whole one fits, so 24 bpp pixels straddle words
        word_ready_o = ce_i && !frame_start_i && (next_s.cnt <= WORD_BITS);
        if (word_valid_i && word_ready_o) begin
            next_s.acc = next_s.acc | ({reorder(word_i, s.ctrl.pixel_width_select,
                                                s.ctrl.word_byte_order_select), 32'h0}
                                       >> next_s.cnt);
            next_s.cnt = next_s.cnt + WORD_BITS;
        end

        if (line_start_i) begin
            next_s.pos = 2'b00;
        end
        // frame start flushes partial data, keeps a presented output
        if (frame_start_i) begin
            for (int k = 0; k < int'(PAT_SETS); k++) begin
                next_s.pidx[k] = (s.pidx[k] >= PAT_LEN[k] - 3'h1) ? 3'h0
                                                                  : 3'(s.pidx[k] + 3'h1);
            end
            next_s.pos     = 2'b00;
            next_s.acc     = 64'h0;
            next_s.cnt     = 7'h00;
            next_s.a_valid = 1'b0;
            next_s.pk      = 11'h000;
            next_s.pk_cnt  = 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s      <= '0;
            s.bus  <= BUS_IDLE;
            s.ctrl <= CTRL_RESET;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign avs_readdata_o   = s.rdata;
    assign pixel_valid_o    = s.o_valid;
    assign panel_data_bus_o = s.o_data;

endmodule

// File: lcd_pixel_palette_dither_assertions.sv
// checker: bus timing, output handshake and tft bit rules
`timescale 1ns/100ps
module lcd_pixel_palette_dither_checker
    import lcd_pixel_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire avs_req_t    avs_req_i,
    input  wire logic [31:0] avs_readdata_o,
    input  wire logic        avs_waitrequest_o,
    input  wire logic [31:0] word_i,
    input  wire logic        word_valid_i,
    input  wire logic        word_ready_o,
    input  wire logic        frame_start_i,
    input  wire logic        line_start_i,
    input  wire logic        pixel_valid_o,
    input  wire logic        pixel_ready_i,
    input  wire logic [23:0] panel_data_bus_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // mode register shadow; partial writes dropped
    ctrl_t ctrl;
    logic  pal_tft;
    logic  lut_rd;
    logic  rd_done;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RESET;
        end else if (ce_i && avs_req_i.write && avs_req_i.address == CTRL_OFFSET
                     && avs_req_i.byteenable == FULL_WORD) begin
            ctrl <= ctrl_t'(avs_req_i.writedata[CTRL_W-1:0]);
        end
    end

    assign pal_tft = ctrl.display_type_select == DISP_TFT && ctrl.pixel_width_select < PW_16;
    assign lut_rd  = avs_req_i.address < CTRL_OFFSET;
    assign rd_done = ce_i && avs_req_i.read && !avs_waitrequest_o;

    a_write_no_wait: assert property (ce_i && avs_req_i.write |-> !avs_waitrequest_o)
        else $error("write not acknowledged in its first cycle");
    a_lut_read_wait: assert property (ce_i && $rose(avs_req_i.read) && lut_rd
        |-> avs_waitrequest_o ##1 avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("table read late");
    a_reg_read_wait: assert property (ce_i && $rose(avs_req_i.read) && !lut_rd
        |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("register read late");
    a_read_upper_zero: assert property (rd_done && lut_rd |-> avs_readdata_o[31:16] == 16'h0000)
        else $error("table read upper half not zero");
    a_unmapped_zero: assert property (rd_done && avs_req_i.address == 12'h408
        |-> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_frame_refuse: assert property (frame_start_i |-> !word_ready_o)
        else $error("word accepted during frame start");
    a_unit_hold: assert property (pixel_valid_o && !pixel_ready_i
        |=> pixel_valid_o && $stable(panel_data_bus_o))
        else $error("output unit changed while stalled");
    a_tft_unused_zero: assert property (pal_tft && pixel_valid_o
        |-> panel_data_bus_o[17:16] == 2'b00 && panel_data_bus_o[9:8] == 2'b00
            && panel_data_bus_o[1:0] == 2'b00)
        else $error("unused tft data bits not zero");

    c_stall: cover property (pixel_valid_o && !pixel_ready_i);
    c_lut_read: cover property (rd_done && lut_rd);
    c_tft_unit: cover property (pal_tft && pixel_valid_o && pixel_ready_i);
endmodule

bind lcd_pixel_palette_dither lcd_pixel_palette_dither_checker
    lcd_pixel_palette_dither_checker_inst (
    .clk_i, .rst_i, .ce_i, .avs_req_i, .avs_readdata_o, .avs_waitrequest_o, .word_i,
    .word_valid_i, .word_ready_o, .frame_start_i, .line_start_i, .pixel_valid_o,
    .pixel_ready_i, .panel_data_bus_o
);

// File: lcd_panel_model.sv
// panel model: collects units, refuses every other cycle while stalled
`timescale 1ns/100ps
module lcd_panel_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        stall_i,
    input  wire logic        pixel_valid_i,
    input  wire logic [23:0] panel_data_bus_i,
    output logic             pixel_ready_o
);
    logic [23:0] got[$];
    logic        tog = 1'b0;

    // combinational ready so it has a value from time zero
    assign pixel_ready_o = !stall_i || tog;

    always @(posedge clk_i) begin
        if (rst_i) begin
            tog <= 1'b0;
        end else begin
            if (pixel_valid_i && pixel_ready_o) got.push_back(panel_data_bus_i);
            tog <= ~tog;
        end
    end
endmodule

// File: test_lcd_pixel_palette_dither.sv
// testbench: table access, tft unpacking and stn dithering of the pixel block
`timescale 1ns/100ps
module test_lcd_pixel_palette_dither
    import lcd_pixel_pkg::*;
;
    localparam logic [27:0] P35 = 28'hA5A5F00;
    localparam logic [27:0] P47 = 28'h9C3A5E6;
    localparam logic [27:0] P23 = 28'hDB60000;
    logic        clk_i         = 1'b0;
    logic        rst_i         = 1'b1;
    logic        ce_i          = 1'b1;
    avs_req_t    req           = '0;
    logic [31:0] word_i        = '0;
    logic        word_valid_i  = 1'b0;
    logic        frame_start_i = 1'b0;
    logic        line_start_i  = 1'b0;
    logic        stall         = 1'b0;
    logic [31:0] rdata;
    logic        wreq;
    logic        word_ready_o;
    logic        pixel_valid_o;
    logic        pixel_ready;
    logic [23:0] bus;
    int          err_total     = 0;
    int          tests_run     = 0;
    int          nf            = 0;
    int          cyc           = 0;

    lcd_pixel_palette_dither lcd_pixel_palette_dither_inst (
        .clk_i, .rst_i, .ce_i, .avs_req_i(req), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .word_i, .word_valid_i, .word_ready_o, .frame_start_i,
        .line_start_i, .pixel_valid_o, .pixel_ready_i(pixel_ready), .panel_data_bus_o(bus));
    lcd_panel_model lcd_panel_model_inst (
        .clk_i, .rst_i, .stall_i(stall), .pixel_valid_i(pixel_valid_o),
        .panel_data_bus_i(bus), .pixel_ready_o(pixel_ready));

    always #20 clk_i = ~clk_i;

    function automatic logic [15:0] ent(input logic [4:0] v, input logic i);
        return {i, v, v, v};
    endfunction
    // equal colour values only, so lane order is moot
    function automatic logic [23:0] tft_u(input logic [15:0] x);
        return {3{x[4:0], x[15], 2'b00}};
    endfunction
    function automatic logic [3:0] pat(input logic [27:0] s, input int j);
        return s[27-4*j -: 4];
    endfunction

    task automatic final_report();
        if (err_total == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_unit(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t unit got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
        req.address    <= a;
        req.writedata  <= d;
        req.byteenable <= be;
        req.write      <= 1'b1;
        @(posedge clk_i);
        while (wreq !== 1'b0) @(posedge clk_i);
        req.write <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
        req.address <= a;
        req.read    <= 1'b1;
        @(posedge clk_i);
        while (wreq !== 1'b0) @(posedge clk_i);
        d = rdata;
        req.read <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr_lut(input logic [7:0] idx, input logic [15:0] e);
        bus_write(LUT_BASE + {2'b00, idx, 2'b00}, {16'hFFFF, e}, FULL_WORD);
    endtask
    task automatic start_frame();
        frame_start_i <= 1'b1;
        @(posedge clk_i);
        frame_start_i <= 1'b0;
        line_start_i  <= 1'b1;
        @(posedge clk_i);
        line_start_i  <= 1'b0;
        nf++;
        lcd_panel_model_inst.got.delete();
    endtask
    task automatic send(input logic [31:0] w[$]);
        foreach (w[k]) begin
            word_i       <= w[k];
            word_valid_i <= 1'b1;
            @(posedge clk_i);
            while (word_ready_o !== 1'b1) @(posedge clk_i);
        end
        word_valid_i <= 1'b0;
    endtask
    task automatic expect_units(input logic [23:0] e[$], input logic [23:0] m);
        while (lcd_panel_model_inst.got.size() < e.size()) @(posedge clk_i);
        foreach (e[k]) check_unit(lcd_panel_model_inst.got[k] & m, e[k]);
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        logic [31:0] r;
        logic [15:0] v;
        logic [23:0] e[$];
        logic [15:0] lv[4];
        logic [3:0]  p;
        logic [7:0]  b;
        int          s;
        lv = '{ent(5'h1F, 1'b1), ent(5'h01, 1'b0), ent(5'h10, 1'b1), ent(5'h0A, 1'b0)};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        bus_read(CTRL_OFFSET, r);
        check_reg(r, 32'h0000_0020);
        bus_read(12'h408, r);
        check_reg(r, 32'h0000_0000);
        // partial writes ignored; upper half never stored
        for (int k = 0; k < 256; k += 51) begin
            v = 16'(k) * 16'h0101 ^ 16'h5A3C;
            bus_write(LUT_BASE + 12'(4 * k), {16'hDEAD, v}, FULL_WORD);
            bus_write(LUT_BASE + 12'(4 * k), 32'h0000_0000, 4'h3);
            bus_read(LUT_BASE + 12'(4 * k), r);
            check_reg(r, {16'h0000, v});
        end
        for (int j = 0; j < 4; j++) wr_lut(8'h11 * 8'(j + 1), lv[j]);
        for (int o = 0; o < 2; o++) begin
            bus_write(CTRL_OFFSET, 32'h0000_000C | (32'(o) << 5), FULL_WORD);
            start_frame();
            send('{32'h1122_3344});
            e.delete();
            for (int j = 0; j < 4; j++) e.push_back(tft_u(lv[o ? j : 3 - j]));
            expect_units(e, 24'hFFFFFF);
        end
        wr_lut(8'hB5, ent(5'h02, 1'b0));
        wr_lut(8'h63, ent(5'h04, 1'b1));
        bus_write(CTRL_OFFSET, 32'h0000_0030, FULL_WORD);
        start_frame();
        send('{32'hD6B5_0C63});
        expect_units('{tft_u(16'hD6B5), tft_u(16'h0C63)}, 24'hFFFFFF);
        wr_lut(8'h00, ent(5'h00, 1'b0));
        wr_lut(8'h01, ent(5'h1F, 1'b1));
        bus_write(CTRL_OFFSET, 32'h0000_0020, FULL_WORD);
        stall <= 1'b1;
        start_frame();
        send('{32'h8000_0001});
        e.delete();
        for (int j = 0; j < 32; j++) e.push_back((j == 0 || j == 31) ? tft_u(lv[0]) : 24'h0);
        expect_units(e, 24'hFFFFFF);
        stall <= 1'b0;
        // patterns and gray entries first
        wr_lut(8'h00, 16'h001E);
        wr_lut(8'h01, 16'h0000);
        wr_lut(8'h02, 16'h0012);
        wr_lut(8'h03, 16'h000C);
        bus_write(PAT_BASE + 12'h014, {4'h0, P35}, FULL_WORD);
        bus_write(PAT_BASE + 12'h018, {4'h0, P47}, FULL_WORD);
        bus_write(PAT_BASE + 12'h010, {4'h0, P23}, FULL_WORD);
        bus_write(CTRL_OFFSET, 32'h0000_0025, FULL_WORD);
        for (int f = 0; f < 8; f++) begin
            start_frame();
            send('{32'h0055_AAFF});
            e = '{24'hF, 24'h0, {20'h0, pat(P35, nf % 5)}, {20'h0, ~pat(P47, nf % 7)}};
            expect_units(e, 24'h00000F);
        end
        wr_lut(8'h05, 16'h501E);
        bus_write(CTRL_OFFSET, 32'h0000_006E, FULL_WORD);
        start_frame();
        send('{32'h0505_0505, 32'h0505_0505});
        p = pat(P23, nf % 3);
        e.delete();
        for (int u = 0; u < 3; u++) begin
            for (int t = 0; t < 8; t++) begin
                s = u * 8 + t;
                b[7-t] = (s % 3 == 0) ? 1'b1 : (s % 3 == 1) ? 1'b0 : p[3 - s % 4];
            end
            e.push_back({16'h0000, b});
        end
        expect_units(e, 24'h0000FF);
        final_report();
    end
endmodule
